// ---- verilog/swd_top.sv ----
// Power-down, wake-up and watchdog control for the small controller
`timescale 1ns/1ns
`include "swd_cfg.svh"
module swd_top #(
  parameter int PINS = `SWD_PIN_COUNT,
  parameter int WAKE_CYCLES = `SWD_WAKE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ext_reset_n_i,
  input wire logic own_osc_tick_i,
  input wire logic rtc_tick_i,
  input wire logic opt_rtc_enable_i,
  input wire logic opt_dog_enable_i,
  input wire swd_pkg::swd_src_t opt_dog_source_i,
  input wire logic opt_dual_clear_i,
  input wire logic [PINS-1:0] opt_pin_wake_en_i,
  input wire logic [PINS-1:0] port_wake_pins_i,
  input wire logic halt_instr_i,
  input wire logic single_dog_clear_instr_i,
  input wire logic first_dog_clear_instr_i,
  input wire logic second_dog_clear_instr_i,
  input wire logic key_write_i,
  input wire logic [3:0] key_wdata_i,
  input wire logic [2:0] prescale_sel_i,
  input wire logic irq_request_i,
  input wire logic irq_enabled_i,
  input wire logic stack_full_i,
  output logic [3:0] dog_enable_key_o,
  output logic dog_active_o,
  output logic power_down_flag_o,
  output logic timeout_flag_o,
  output logic sys_clk_run_o,
  output logic rtc_run_o,
  output logic hold_state_o,
  output logic fetch_enable_o,
  output logic dog_reset_o,
  output logic pc_sp_reset_o,
  output logic irq_service_o,
  output logic irq_pending_hold_o,
  output swd_pkg::swd_wake_t wake_cause_o
);
  import swd_pkg::*;
  localparam int WCW = $clog2(WAKE_CYCLES + 1);
  if (PINS < 1 || PINS > 8)
  begin : g_bad_pins
    $error("PINS must be 1 to 8");
  end
  if (WAKE_CYCLES < 1)
  begin : g_bad_wake
    $error("WAKE_CYCLES must be positive");
  end

  // Pin side inputs pass the three-stage synchroniser
  logic [PINS-1:0] pin_lvl;
  logic ext_reset_n_lvl;
  swd_sync #(.WIDTH(PINS), .RST_VAL(1'b1)) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i(port_wake_pins_i),
    .level_o(pin_lvl)
  );
  swd_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_rst_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i(ext_reset_n_i),
    .level_o(ext_reset_n_lvl)
  );

  swd_state_t state_q;
  swd_state_t state_d;
  logic [WCW-1:0] wake_cnt_q;
  logic [PINS-1:0] pin_prev_q;
  logic [3:0] key_q;
  logic pdf_q;
  logic to_q;
  logic clr_last_second_q;
  logic clr_seen_q;
  logic irq_armed_q;
  logic [1:0] quarter_q;
  swd_wake_t cause_q;
  logic dog_reset_q;
  logic pcsp_q;
  logic svc_q;
  logic pend_q;

  // Enable decode shared by the clear and timeout paths
  function automatic logic dog_on(input logic opt_en, input logic [3:0] key);
    dog_on = opt_en || (key != `SWD_KEY_OFF);
  endfunction

  wire dog_en = dog_on(opt_dog_enable_i, key_q);
  wire running = (state_q == SWD_RUN);
  wire halting = (state_q == SWD_HALT);
  wire ext_rst_low = !ext_reset_n_lvl;
  // Halt is the only path into power-down
  wire do_halt = running && halt_instr_i;

  // Clear instructions: single mode direct, dual mode must alternate
  wire clr_first_ok = first_dog_clear_instr_i && (!clr_seen_q || clr_last_second_q);
  wire clr_second_ok = second_dog_clear_instr_i && (!clr_seen_q || !clr_last_second_q);
  wire clr_dual = clr_first_ok || clr_second_ok;
  wire clr_instr_raw = opt_dual_clear_i ? clr_dual : single_dog_clear_instr_i;
  wire clr_instr = running && dog_en && clr_instr_raw;

  // Clock source tick; system quarter clock stops in power-down
  wire quarter_tick = (quarter_q == 2'h3) && !halting;
  wire rtc_tick_ok = rtc_tick_i && opt_rtc_enable_i;
  wire src_tick = (opt_dog_source_i == SWD_SRC_OWN) ? own_osc_tick_i :
                  (opt_dog_source_i == SWD_SRC_RTC) ? rtc_tick_ok : quarter_tick;
  wire dog_tick = dog_en && src_tick && (state_q != SWD_WAKE);
  // Counter cleared by reset pin, clear instructions or halt
  wire dog_clear = ext_rst_low || clr_instr || do_halt;
  logic dog_ovf;
  swd_dog_counter #(.BASE_DIV(`SWD_BASE_DIV)) u_dog (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .tick_i(dog_tick),
    .clear_i(dog_clear),
    .prescale_sel_i(prescale_sel_i),
    .overflow_o(dog_ovf)
  );
  wire dog_ovf_hit = dog_ovf && dog_en;

  // Wake sources while halted
  wire [PINS-1:0] pin_fall = pin_prev_q & ~pin_lvl & opt_pin_wake_en_i;
  wire pin_wake = halting && (|pin_fall);
  wire irq_wake = halting && irq_armed_q && irq_request_i;
  wire dog_wake = halting && dog_ovf_hit;
  wire any_wake = pin_wake || irq_wake || dog_wake;
  wire wake_done = (state_q == SWD_WAKE) && (wake_cnt_q == WCW'(WAKE_CYCLES - 1));
  wire irq_take = irq_enabled_i && !stack_full_i;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SWD_RUN:
        if (do_halt)
          state_d = SWD_HALT;
      SWD_HALT:
        if (any_wake)
          state_d = SWD_WAKE;
      SWD_WAKE:
        if (wake_done)
          state_d = SWD_RUN;
      default:
        state_d = SWD_RUN;
    endcase
    // External reset wins over everything as a full reset
    if (ext_rst_low)
      state_d = SWD_RUN;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= SWD_RUN;
      wake_cnt_q <= '0;
      pin_prev_q <= {PINS{1'b1}};
      quarter_q <= 2'h0;
      cause_q <= SWD_WK_NONE;
      irq_armed_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pin_prev_q <= pin_lvl;
      if (!halting)
        quarter_q <= quarter_q + 2'h1;
      // Delay counted on the restarted system clock
      if (state_q == SWD_WAKE && !wake_done)
        wake_cnt_q <= wake_cnt_q + 1'b1;
      else
        wake_cnt_q <= '0;
      // An interrupt already flagged at halt never arms
      if (do_halt)
        irq_armed_q <= !irq_request_i;
      if (pin_wake)
        cause_q <= SWD_WK_PIN;
      else if (irq_wake)
        cause_q <= SWD_WK_IRQ;
      else if (dog_wake)
        cause_q <= SWD_WK_DOG;
      else if (ext_rst_low)
        cause_q <= SWD_WK_NONE;
    end
  end

  // Enable key, status flags and the clear alternation
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      key_q <= `SWD_KEY_RESET;
      pdf_q <= 1'b0;
      to_q <= 1'b0;
      clr_last_second_q <= 1'b0;
      clr_seen_q <= 1'b0;
    end
    else
    begin
      if (ext_rst_low)
        key_q <= `SWD_KEY_RESET;
      else if (key_write_i && running)
        key_q <= key_wdata_i;
      // Halt sets power-down flag; clear instruction drops it
      if (do_halt)
        pdf_q <= 1'b1;
      else if (clr_instr)
        pdf_q <= 1'b0;
      // Timeout sets the flag over any clear
      if (dog_ovf_hit)
        to_q <= 1'b1;
      else if (do_halt || clr_instr)
        to_q <= 1'b0;
      if (clr_instr && opt_dual_clear_i)
      begin
        clr_seen_q <= 1'b1;
        clr_last_second_q <= clr_second_ok;
      end
    end
  end

  // Reset and interrupt outcome pulses
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dog_reset_q <= 1'b0;
      pcsp_q <= 1'b0;
      svc_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else
    begin
      // Running timeout is a device reset
      dog_reset_q <= dog_ovf_hit && running;
      // Halted timeout resets only counter and stack after the delay
      pcsp_q <= wake_done && (cause_q == SWD_WK_DOG);
      // Interrupt wake: service or leave pending
      svc_q <= wake_done && (cause_q == SWD_WK_IRQ) && irq_take;
      if (wake_done && cause_q == SWD_WK_IRQ && !irq_take)
        pend_q <= 1'b1;
      else if (irq_take || !irq_request_i)
        pend_q <= 1'b0;
    end
  end

  assign dog_enable_key_o = key_q;
  assign dog_active_o = dog_en;
  assign power_down_flag_o = pdf_q;
  assign timeout_flag_o = to_q;
  assign sys_clk_run_o = !halting;
  assign rtc_run_o = opt_rtc_enable_i;
  // State is frozen, not reset, across power-down
  assign hold_state_o = !running;
  assign fetch_enable_o = running;
  assign dog_reset_o = dog_reset_q;
  assign pc_sp_reset_o = pcsp_q;
  assign irq_service_o = svc_q;
  assign irq_pending_hold_o = pend_q;
  assign wake_cause_o = cause_q;
endmodule

// ---- pkg/swd_cfg.svh ----
// Constants for the sleep, wake-up and watchdog block
// How it works
// - Power-down is entered only by the halt instruction.
// - Halt stops the system clock and freezes execution; the real-time clock keeps running.
// - Memory, registers and ports hold their values through power-down.
// - Halt clears the watchdog; it counts on own or real-time clock, stops on system clock.
// - Halt sets the power-down flag and clears the timeout flag.
// - Wake on external reset, pin falling edge, interrupt or watchdog overflow.
// - Reset wake is a full reset; watchdog wake resets only counter and stack, not the device.
// - Power-down flag cleared by power-up or clear instruction, set only by halt.
// - Each of seven pins has its own wake enable; pin wake resumes after halt.
// - Disabled or stack-full interrupt wake resumes after halt; request stays pending.
// - Enabled interrupt with free stack level takes the normal interrupt response.
// - An interrupt already pending at halt cannot wake the device.
// - Pin, interrupt and watchdog wakes wait 1024 system clocks, reset wake none; interrupt wake adds further cycles.
// - Watchdog is off only when both option and control key select disable.
// - Key 1010B disables, reset value; any other key enables; 0101B recommended.
// - With the watchdog off every watchdog instruction is a no-operation.
// - Watchdog clock is own oscillator, real-time clock or system clock divided by four.
// - Watchdog clock divides by 256 then a 7-bit prescaler set by three select bits.
// - Timeout in normal running resets the device and sets the timeout flag.
// - Timeout in power-down wakes, sets timeout flag, resets only counter and stack.
// - Watchdog counter cleared by reset pin low, clear instructions or halt.
// - Single mode: one clear instruction; dual mode: the two must alternate.
`ifndef SWD_CFG_SVH
`define SWD_CFG_SVH
`define SWD_KEY_W 4
`define SWD_KEY_OFF 4'hA
`define SWD_KEY_RESET 4'hA
`define SWD_WAKE_CYCLES 1024
`define SWD_BASE_DIV 256
`define SWD_QUARTER_DIV 4
`define SWD_PIN_COUNT 7
`endif

// ---- pkg/swd_pkg.sv ----
// Types for the sleep, wake-up and watchdog block
package swd_pkg;
  typedef enum logic [1:0] {
    SWD_SRC_OWN = 2'h0,
    SWD_SRC_RTC = 2'h1,
    SWD_SRC_QUARTER = 2'h2
  } swd_src_t;
  typedef enum logic [2:0] {
    SWD_RUN = 3'h1,
    SWD_HALT = 3'h2,
    SWD_WAKE = 3'h4
  } swd_state_t;
  typedef enum logic [1:0] {
    SWD_WK_NONE = 2'h0,
    SWD_WK_PIN = 2'h1,
    SWD_WK_IRQ = 2'h2,
    SWD_WK_DOG = 2'h3
  } swd_wake_t;
endpackage

// ---- verilog/swd_sync.sv ----
// Three-stage input synchroniser with agreement on the last two stages
`timescale 1ns/1ns
module swd_sync #(
  parameter int WIDTH = 1,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;
  logic [WIDTH-1:0] lvl_d;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      // A change counts only once the second and third stage agree
      assign lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
    end
  endgenerate
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_q <= {WIDTH{RST_VAL}};
      s2_q <= {WIDTH{RST_VAL}};
      s3_q <= {WIDTH{RST_VAL}};
      lvl_q <= {WIDTH{RST_VAL}};
    end
    else
    begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end
  assign level_o = lvl_q;
endmodule

// ---- verilog/swd_dog_counter.sv ----
// Watchdog divider chain: 8-bit base stage then 7-bit prescaler
`timescale 1ns/1ns
`include "swd_cfg.svh"
module swd_dog_counter #(
  parameter int BASE_DIV = `SWD_BASE_DIV
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic clear_i,
  input wire logic [2:0] prescale_sel_i,
  output logic overflow_o
);
  import swd_pkg::*;
  localparam int BW = $clog2(BASE_DIV);
  if (BASE_DIV < 2 || (1 << BW) != BASE_DIV)
  begin : g_bad_div
    $error("BASE_DIV must be a power of two");
  end
  logic [BW-1:0] base_q;
  logic [6:0] pre_q;
  logic base_wrap;
  logic [7:0] pre_next;
  logic pre_wrap;
  assign base_wrap = tick_i && (base_q == {BW{1'b1}});
  assign pre_next = {1'b0, pre_q} + 8'h01;
  // Ratio is 2^sel, so sel all ones gives 1:128
  assign pre_wrap = base_wrap && pre_next[prescale_sel_i];
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      base_q <= '0;
      pre_q <= 7'h00;
      overflow_o <= 1'b0;
    end
    else if (clear_i)
    begin
      base_q <= '0;
      pre_q <= 7'h00;
      overflow_o <= 1'b0;
    end
    else
    begin
      if (tick_i)
        base_q <= base_q + 1'b1;
      if (pre_wrap)
        pre_q <= 7'h00;
      else if (base_wrap)
        pre_q <= pre_next[6:0];
      overflow_o <= pre_wrap;
    end
  end
endmodule

// ---- dv/swd_top_props.sv ----
// Port-level assertions for the power-down, wake-up and watchdog controller
`timescale 1ns/1ns
`include "swd_cfg.svh"
module swd_checker #(
  parameter int WAKE_CYCLES = `SWD_WAKE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic halt_instr_i,
  input wire logic key_write_i,
  input wire logic [3:0] key_wdata_i,
  input wire logic opt_dog_enable_i,
  input wire logic irq_enabled_i,
  input wire logic stack_full_i,
  input wire logic [3:0] dog_enable_key_o,
  input wire logic dog_active_o,
  input wire logic power_down_flag_o,
  input wire logic timeout_flag_o,
  input wire logic sys_clk_run_o,
  input wire logic hold_state_o,
  input wire logic fetch_enable_o,
  input wire logic dog_reset_o,
  input wire logic pc_sp_reset_o,
  input wire logic irq_service_o,
  input wire swd_pkg::swd_wake_t wake_cause_o
);
  import swd_pkg::*;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // Cycles spent in the wake delay, zero elsewhere
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  assign cnt_d = (hold_state_o && sys_clk_run_o) ? cnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_d;
  end
  sequence s_halt_taken;
    halt_instr_i && fetch_enable_o;
  endsequence
  sequence s_halted;
    power_down_flag_o && !timeout_flag_o && !sys_clk_run_o && !fetch_enable_o;
  endsequence
  a_halt_sets_flags: assert property (s_halt_taken |=> s_halted)
    else $error("halt did not stop and flag");
  a_wake_delay_exact: assert property (
    $rose(fetch_enable_o) && wake_cause_o != SWD_WK_NONE |-> cnt_q == WAKE_CYCLES)
    else $error("wake delay length wrong");
  a_wake_delay_bound: assert property (cnt_q <= WAKE_CYCLES)
    else $error("wake delay overran");
  a_pdf_by_halt: assert property ($rose(power_down_flag_o) |-> $past(halt_instr_i))
    else $error("power-down flag set without halt");
  a_dog_reset_run: assert property (
    dog_reset_o |-> timeout_flag_o && $past(fetch_enable_o))
    else $error("running timeout flag missing");
  a_pcsp_dog_wake: assert property (
    pc_sp_reset_o |-> timeout_flag_o && wake_cause_o == SWD_WK_DOG)
    else $error("counter reset without dog wake");
  a_irq_service_ok: assert property (irq_service_o
    |-> wake_cause_o == SWD_WK_IRQ && irq_enabled_i && !stack_full_i)
    else $error("interrupt serviced wrongly");
  a_dog_on_map: assert property (dog_active_o
    == (opt_dog_enable_i || dog_enable_key_o != `SWD_KEY_OFF))
    else $error("watchdog on state wrong");
  a_key_write_lands: assert property (key_write_i && fetch_enable_o
    |=> dog_enable_key_o == $past(key_wdata_i))
    else $error("key write lost");
endmodule

bind swd_top swd_checker #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (.*);

// ---- dv/swd_core_model.sv ----
// Core-side model issuing halt, clear and key-write instruction pulses
`timescale 1ns/1ns
module swd_core_model (
  input wire logic ref_clk_i,
  input wire logic fetch_enable_i,
  output logic halt_o,
  output logic clr_single_o,
  output logic clr_first_o,
  output logic clr_second_o,
  output logic key_write_o,
  output logic [3:0] key_wdata_o
);
  initial
  begin
    {halt_o, clr_single_o, clr_first_o, clr_second_o, key_write_o} = 5'h00;
    key_wdata_o = 4'h0;
  end
  // Kind 0 halt, 1 single, 2 first, 3 second clear, 4 key write
  task automatic exec(input int kind, input logic [3:0] key);
    @(negedge ref_clk_i);
    // Frozen core fetches nothing, so nothing issues while blocked
    if (fetch_enable_i === 1'b1)
    begin
      key_wdata_o = key;
      {halt_o, clr_single_o, clr_first_o, clr_second_o, key_write_o} = 5'h10 >> kind;
      @(negedge ref_clk_i);
      {halt_o, clr_single_o, clr_first_o, clr_second_o, key_write_o} = 5'h00;
      // Data bus no longer holds the written key
      key_wdata_o = ~key;
    end
  endtask
endmodule

// ---- dv/swd_top_tb_top.sv ----
// Directed bench for the power-down, wake-up and watchdog controller
`timescale 1ns/1ns
module swd_top_tb_top;
  import swd_pkg::*;
  localparam int WK = 16;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ext_reset_n_i = 1'b1;
  logic own_osc_tick_i = 1'b0;
  logic tick_en = 1'b0;
  logic opt_rtc_enable_i = 1'b1;
  logic opt_dog_enable_i = 1'b0;
  logic opt_dual_clear_i = 1'b0;
  swd_src_t opt_dog_source_i = SWD_SRC_OWN;
  logic [6:0] opt_pin_wake_en_i = 7'h08;
  logic [6:0] port_wake_pins_i = 7'h7F;
  // Ratio 1:2, so one timeout per 512 ticks, about 1024 cycles
  logic [2:0] prescale_sel_i = 3'h1;
  logic irq_request_i = 1'b0;
  logic irq_enabled_i = 1'b1;
  logic stack_full_i = 1'b0;
  logic halt_instr_i, single_dog_clear_instr_i, first_dog_clear_instr_i;
  logic second_dog_clear_instr_i, key_write_i;
  logic [3:0] key_wdata_i, dog_enable_key_o;
  logic dog_active_o, power_down_flag_o, timeout_flag_o, sys_clk_run_o, rtc_run_o;
  logic hold_state_o, fetch_enable_o, dog_reset_o, pc_sp_reset_o, irq_service_o;
  logic irq_pending_hold_o;
  swd_wake_t wake_cause_o;
  int failures = 0;
  int checks_done = 0;
  int n_dog = 0;
  int n_pcs = 0;
  int n_svc = 0;
  swd_top #(.WAKE_CYCLES(WK)) dut (.*, .rtc_tick_i(own_osc_tick_i));
  swd_core_model u_core (.ref_clk_i, .fetch_enable_i(fetch_enable_o), .halt_o(halt_instr_i),
    .clr_single_o(single_dog_clear_instr_i), .clr_first_o(first_dog_clear_instr_i),
    .clr_second_o(second_dog_clear_instr_i), .key_write_o(key_write_i),
    .key_wdata_o(key_wdata_i));
  always #10 ref_clk_i = ~ref_clk_i;
  // Oscillator tick every other cycle
  always @(negedge ref_clk_i)
    own_osc_tick_i <= tick_en & ~own_osc_tick_i;
  always @(posedge ref_clk_i)
  begin
    n_dog <= n_dog + int'(dog_reset_o === 1'b1);
    n_pcs <= n_pcs + int'(pc_sp_reset_o === 1'b1);
    n_svc <= n_svc + int'(irq_service_o === 1'b1);
  end
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string nm);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic wait_fetch(input int lim);
    int i;
    i = 0;
    while (fetch_enable_o !== 1'b1 && i < lim)
    begin
      idle(1);
      i++;
    end
    chk(fetch_enable_o, 1'b1, "fetch");
    if (i == lim)
      test_done();
  endtask
  initial
  begin
    idle(3);
    rst_i = 1'b0;
    idle(2);
    chk(dog_enable_key_o, 4'hA, "key_rst");
    chk(dog_active_o, 1'b0, "dog_off");
    opt_dog_enable_i = 1'b1;
    idle(1);
    chk(dog_active_o, 1'b1, "dog_opt");
    opt_dog_enable_i = 1'b0;
    u_core.exec(0, 4'h0);
    chk(power_down_flag_o, 1'b1, "pdf");
    chk(timeout_flag_o, 1'b0, "to");
    chk(sys_clk_run_o, 1'b0, "sysclk");
    chk(rtc_run_o, 1'b1, "rtc");
    port_wake_pins_i = 7'h7E;
    idle(20);
    chk(sys_clk_run_o, 1'b0, "pin_mask");
    port_wake_pins_i = 7'h76;
    wait_fetch(WK + 20);
    chk(wake_cause_o, SWD_WK_PIN, "pin_cause");
    port_wake_pins_i = 7'h7F;
    u_core.exec(1, 4'h0);
    chk(power_down_flag_o, 1'b1, "clr_nop");
    u_core.exec(4, 4'h5);
    chk(dog_active_o, 1'b1, "key_on");
    u_core.exec(1, 4'h0);
    chk(power_down_flag_o, 1'b0, "pdf_clr");
    tick_en = 1'b1;
    idle(900);
    chk(4'(n_dog), 4'h0, "early_to");
    idle(200);
    chk(4'(n_dog), 4'h1, "run_to");
    chk(timeout_flag_o, 1'b1, "to_set");
    u_core.exec(4, 4'h5);
    opt_dual_clear_i = 1'b1;
    u_core.exec(3, 4'h0);
    idle(600);
    u_core.exec(2, 4'h0);
    idle(600);
    chk(4'(n_dog), 4'h1, "dual_alt");
    u_core.exec(2, 4'h0);
    idle(500);
    chk(4'(n_dog), 4'h2, "dual_rep");
    u_core.exec(4, 4'h5);
    u_core.exec(0, 4'h0);
    idle(990);
    chk(sys_clk_run_o, 1'b0, "halt_clr");
    wait_fetch(200 + WK);
    chk(wake_cause_o, SWD_WK_DOG, "dog_cause");
    chk(timeout_flag_o, 1'b1, "dog_to");
    chk(power_down_flag_o, 1'b1, "pdf_kept");
    // Pulse counter lags the pulse by one edge
    idle(2);
    chk(4'(n_pcs), 4'h1, "pc_sp");
    opt_dog_source_i = SWD_SRC_QUARTER;
    u_core.exec(0, 4'h0);
    idle(2500);
    chk(sys_clk_run_o, 1'b0, "quarter");
    irq_request_i = 1'b1;
    wait_fetch(WK + 20);
    chk(wake_cause_o, SWD_WK_IRQ, "irq_cause");
    idle(4);
    chk(4'(n_svc), 4'h1, "irq_svc");
    irq_request_i = 1'b0;
    u_core.exec(4, 4'hA);
    chk(dog_active_o, 1'b0, "key_off");
    irq_enabled_i = 1'b0;
    u_core.exec(0, 4'h0);
    irq_request_i = 1'b1;
    wait_fetch(WK + 20);
    idle(4);
    chk(irq_pending_hold_o, 1'b1, "irq_pend");
    chk(4'(n_svc), 4'h1, "no_svc");
    u_core.exec(0, 4'h0);
    idle(50);
    chk(sys_clk_run_o, 1'b0, "pend_halt");
    ext_reset_n_i = 1'b0;
    wait_fetch(20);
    chk(wake_cause_o, SWD_WK_NONE, "ext_cause");
    chk(power_down_flag_o, 1'b1, "ext_pdf");
    ext_reset_n_i = 1'b1;
    irq_request_i = 1'b0;
    idle(3);
    chk(irq_pending_hold_o, 1'b0, "pend_drop");
    test_done();
  end
endmodule
